// ==== design/plwdt_cnt_if.sv ====
/*
 * Carrier between the watchdog control logic and its overflow counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface plwdt_cnt_if;
   logic       clear;
   logic       run;
   logic [1:0] sel;
   logic       overflow;

   modport ctl (output clear, output run, output sel, input overflow);
   modport cnt (input clear, input run, input sel, output overflow);
endinterface

// ==== design/plwdt_counter.sv ====
/*
 * Overflow counter of the program loop watchdog.
 * Assumes clear is a one-cycle pulse and run stays high once set.
 */
`timescale 1ns/1ps
module plwdt_counter #(
   parameter logic [23:0] OVF_CNT_0 = plwdt_pkg::OVF_CNT_0,
   parameter logic [23:0] OVF_CNT_1 = plwdt_pkg::OVF_CNT_1,
   parameter logic [23:0] OVF_CNT_2 = plwdt_pkg::OVF_CNT_2,
   parameter logic [23:0] OVF_CNT_3 = plwdt_pkg::OVF_CNT_3
) (
   // Clock and reset
   input  wire logic    clk_i,
   input  wire logic    rst_b_i,
   // Control from the mode register logic
   plwdt_cnt_if.cnt     cnt_p
);

   logic [plwdt_pkg::CNT_W-1:0] count_r;
   logic                        done_r;
   logic                        ovf_r;
   logic [plwdt_pkg::CNT_W-1:0] limit;

   // Overflow count chosen by the two interval select bits
   function automatic logic [23:0] limit_of(input logic [1:0] sel);
      unique case (sel)
         2'd0: limit_of = OVF_CNT_0;
         2'd1: limit_of = OVF_CNT_1;
         2'd2: limit_of = OVF_CNT_2;
         2'd3: limit_of = OVF_CNT_3;
      endcase
   endfunction

   assign limit = limit_of(cnt_p.sel);

   // Count up; stop after overflow so the request fires only once
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         count_r <= '0;
         done_r  <= 1'b0;
         ovf_r   <= 1'b0;
      end else if (cnt_p.clear) begin
         count_r <= '0; // RULE_01
         done_r  <= 1'b0; // RULE_03
         ovf_r   <= 1'b0;
      end else if (cnt_p.run && !done_r) begin
         if (count_r == limit - 24'h00_0001) begin
            count_r <= '0;
            done_r  <= 1'b1;
            ovf_r   <= 1'b1; // RULE_02
         end else begin
            count_r <= count_r + 24'h00_0001;
            ovf_r   <= 1'b0;
         end
      end else begin
         ovf_r <= 1'b0;
      end
   end

   assign cnt_p.overflow = ovf_r;

endmodule

// ==== design/plwdt_pkg.sv ====
/*
 * Shared constants of the program loop watchdog: mode register layout,
 * reset value and default overflow counts.
 * Assumes nothing of its surroundings; included by package name only.
 */
package plwdt_pkg;
   // Mode register layout
   localparam int unsigned MODE_W       = 8;
   localparam logic [7:0]  MODE_RST     = 8'h00;
   localparam int unsigned RUN_BIT      = 7;
   localparam int unsigned PRIO_BIT     = 4;
   localparam int unsigned SEL_HI_BIT   = 2;
   localparam int unsigned SEL_LO_BIT   = 1;

   // Counter width and default overflow counts, one per interval setting
   localparam int unsigned CNT_W        = 24;
   localparam logic [23:0] OVF_CNT_0    = 24'h02_0000;
   localparam logic [23:0] OVF_CNT_1    = 24'h08_0000;
   localparam logic [23:0] OVF_CNT_2    = 24'h20_0000;
   localparam logic [23:0] OVF_CNT_3    = 24'h80_0000;

   // Width of the instruction address captured on an operand error
   localparam int unsigned ADDR_W       = 20;
endpackage

// ==== design/plwdt_top.sv ====
/*
 * Program loop watchdog: protected mode register, overflow counter and
 * arbitration between the watchdog and the pin non-maskable interrupt.
 * Assumes the core decodes its instructions and presents each write
 * aimed at the mode register as a one-cycle request on clk_i.
 * The pin request passes a two-flop synchroniser, so it is seen
 * three cycles after the pin rises; the core's acknowledge is local.
 */
// Functional notes
// RULE_01: Start bit clears counter, counting from zero.
// RULE_02: Selected overflow time elapsed raises watchdog request.
// RULE_03: Start bit again before overflow restarts quietly.
// RULE_04: Only dedicated write with complement bytes accepted.
// RULE_05: Non-complement bytes: no change, operand error raised.
// RULE_06: Other write kinds discarded, no error raised.
// RULE_07: After first start, register contents locked.
// RULE_08: Software cannot stop it; restart always allowed.
// RULE_09: Register readable any time without side effects.
// RULE_10: Reset clears register, stopped and unlocked.
// RULE_11: Eight-bit register, one bit selects priority.
// RULE_12: Pin priority holds watchdog until handler ends.
// RULE_13: Software writes the same value every start.
// RULE_14: Operand error handler reinitialises the system.
// RULE_15: Start bit is MSB; overflow counts are parameters.
`timescale 1ns/1ps
module plwdt_top #(
   parameter logic [23:0] OVF_CNT_0 = plwdt_pkg::OVF_CNT_0,
   parameter logic [23:0] OVF_CNT_1 = plwdt_pkg::OVF_CNT_1,
   parameter logic [23:0] OVF_CNT_2 = plwdt_pkg::OVF_CNT_2,
   parameter logic [23:0] OVF_CNT_3 = plwdt_pkg::OVF_CNT_3
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   // Write request from the core's instruction decoder
   input  wire logic                         wr_valid_i,
   input  wire logic                         wr_dedicated_i,
   input  wire logic [7:0]                   wr_op3_i,
   input  wire logic [7:0]                   wr_op4_i,
   input  wire logic [plwdt_pkg::ADDR_W-1:0] instr_addr_i,
   // Register read-back
   output logic [plwdt_pkg::MODE_W-1:0]      mode_o,
   // Operand error report
   output logic                              operand_err_o,
   output logic [plwdt_pkg::ADDR_W-1:0]      err_addr_o,
   // Non-maskable interrupt handshake with the core
   input  wire logic                         nmi_pin_i,
   input  wire logic                         nmi_ack_i,
   input  wire logic                         nmi_done_i,
   output logic                              watchdog_overflow_irq_o,
   output logic                              pin_irq_o,
   output logic                              grant_wdt_o,
   output logic                              grant_pin_o
);

   plwdt_cnt_if cnt_c ();

   logic [plwdt_pkg::MODE_W-1:0] mode_r;
   logic                         restart_r;
   logic                         pin_s1_r;
   logic                         pin_s2_r;
   logic                         pin_s3_r;
   logic                         wdt_pend_r;
   logic                         pin_pend_r;
   logic                         pin_busy_r;
   logic                         ded_wr;
   logic                         cmpl_ok;
   logic                         acc_wr;
   logic                         bad_wr;
   logic                         wdt_first;
   logic                         gw_c;
   logic                         gp_c;

   // Trailing code bytes must be exact complements of each other
   function automatic logic pair_ok(input logic [7:0] data,
                                    input logic [7:0] chk);
      pair_ok = (data == ~chk);
   endfunction

   // Interval index from a mode value, high select bit first
   function automatic logic [1:0] sel_of(input logic [7:0] mode);
      sel_of = {mode[plwdt_pkg::SEL_HI_BIT],
                mode[plwdt_pkg::SEL_LO_BIT]};
   endfunction

   // Start bit of a mode value
   function automatic logic run_of(input logic [7:0] mode);
      run_of = mode[plwdt_pkg::RUN_BIT];
   endfunction

   // Only the dedicated write form is looked at; all others drop here.
   // A stray register move or bit set in a runaway loop must not be
   // able to feed the watchdog, so it raises nothing either.
   assign ded_wr    = wr_valid_i && wr_dedicated_i; // RULE_06
   assign cmpl_ok   = pair_ok(wr_op3_i, wr_op4_i); // RULE_04
   assign acc_wr    = ded_wr && cmpl_ok;
   assign bad_wr    = ded_wr && !cmpl_ok; // RULE_05
   assign wdt_first = mode_r[plwdt_pkg::PRIO_BIT]; // RULE_11

   // Mode register; the start bit itself is the lock.
   // No separate lock flop, so no later write can ever unlock it.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         mode_r <= plwdt_pkg::MODE_RST; // RULE_10
      end else if (acc_wr && !run_of(mode_r)) begin
         mode_r <= wr_op3_i; // RULE_07
      end
   end

   // Restart pulse; a locked register still lets the counter clear.
   // A zero start bit clears nothing, so such a write cannot feed it.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         restart_r <= 1'b0;
      end else begin
         restart_r <= acc_wr && run_of(wr_op3_i); // RULE_08
      end
   end

   // Operand error: report with the offending instruction's address.
   // The address holds until the next error, for the handler to read.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         operand_err_o <= 1'b0;
         err_addr_o    <= '0;
      end else begin
         operand_err_o <= bad_wr; // RULE_05
         if (bad_wr) begin
            err_addr_o <= instr_addr_i; // RULE_05
         end
      end
   end

   // Counter control; run only falls at reset
   assign cnt_c.clear = restart_r; // RULE_01
   assign cnt_c.run   = run_of(mode_r); // RULE_08
   assign cnt_c.sel   = sel_of(mode_r); // RULE_15

   // Overflow counter; interval read live from the locked register
   plwdt_counter #(
      .OVF_CNT_0 (OVF_CNT_0),
      .OVF_CNT_1 (OVF_CNT_1),
      .OVF_CNT_2 (OVF_CNT_2),
      .OVF_CNT_3 (OVF_CNT_3)
   ) u_counter (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .cnt_p   (cnt_c.cnt)
   );

   // Pin is asynchronous: two flops first, edge taken after them.
   // All three idle low after reset, matching the pin, so no false edge.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= nmi_pin_i;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // Grant decode; with pin first, a pin handler in service blocks the watchdog.
   // With pin first the watchdog never nests in the pin handler; it waits
   // for the pin handler's return, which the core reports.
   always_comb begin
      gw_c = nmi_ack_i && wdt_pend_r
             && (wdt_first || (!pin_pend_r && !pin_busy_r)); // RULE_12
      gp_c = nmi_ack_i && pin_pend_r && !gw_c; // RULE_11
   end

   // Watchdog pending; a fresh overflow beats its own grant
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wdt_pend_r <= 1'b0;
      end else if (cnt_c.overflow) begin
         wdt_pend_r <= 1'b1; // RULE_02
      end else if (gw_c) begin
         wdt_pend_r <= 1'b0;
      end
   end

   // Pin pending; a fresh edge beats its own grant
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_pend_r <= 1'b0;
      end else if (pin_s2_r && !pin_s3_r) begin
         pin_pend_r <= 1'b1;
      end else if (gp_c) begin
         pin_pend_r <= 1'b0;
      end
   end

   // Pin handler in service until the core reports its return.
   // A grant in the same cycle as a return wins, keeping it busy.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_busy_r <= 1'b0;
      end else if (gp_c) begin
         pin_busy_r <= 1'b1;
      end else if (nmi_done_i) begin
         pin_busy_r <= 1'b0; // RULE_12
      end
   end

   // Registered grants, one-cycle pulses.
   // Registered so the core sees clean strobes, at one cycle's cost.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         grant_wdt_o <= 1'b0;
         grant_pin_o <= 1'b0;
      end else begin
         grant_wdt_o <= gw_c;
         grant_pin_o <= gp_c;
      end
   end

   // Outputs straight from flops; reading has no side effect.
   // Pending flags stand until granted, then drop with the grant.
   assign mode_o                  = mode_r; // RULE_09
   assign watchdog_overflow_irq_o = wdt_pend_r;
   assign pin_irq_o               = pin_pend_r;

endmodule

// ==== verification/plwdt_assertions.sv ====
/* Port checker for the watchdog top, bound onto plwdt_top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module plwdt_chk (
   // Clock, reset and write request
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       wr_valid_i,
   input wire logic       wr_dedicated_i,
   input wire logic [7:0] wr_op3_i,
   input wire logic [7:0] wr_op4_i,
   // Register, error and interrupts
   input wire logic [7:0] mode_o,
   input wire logic       operand_err_o,
   input wire logic       nmi_ack_i,
   input wire logic       pin_irq_o,
   input wire logic       watchdog_overflow_irq_o,
   input wire logic       grant_wdt_o,
   // Pin handler bookkeeping
   input wire logic       grant_pin_o,
   input wire logic       nmi_done_i
);
   // Dedicated write, and one with a good complement
   wire logic ded_w = wr_valid_i && wr_dedicated_i;
   wire logic ok_w  = ded_w && (wr_op3_i == ~wr_op4_i);
   // Pin handler in service, from its grant to the core's return
   logic pin_srv_r;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_srv_r <= 1'b0;
      end else if (grant_pin_o) begin
         pin_srv_r <= 1'b1;
      end else if (nmi_done_i) begin
         pin_srv_r <= 1'b0;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wr_take_a: assert property (
      ok_w && !mode_o[7] |=> mode_o == $past(wr_op3_i)) else $error("take");
   bad_cmpl_a: assert property (
      ded_w && !ok_w |=> operand_err_o && $stable(mode_o)) else $error("cmpl");
   err_cause_a: assert property (
      operand_err_o |-> $past(ded_w && !ok_w)) else $error("err cause");
   mode_cause_a: assert property (
      $changed(mode_o) |-> $past(ok_w)) else $error("mode cause");
   lock_hold_a: assert property (
      mode_o[7] |=> $stable(mode_o)) else $error("lock");
   pin_first_a: assert property (
      nmi_ack_i && pin_irq_o && !mode_o[4] |=> !grant_wdt_o) else $error("pin");
   wdt_first_a: assert property (
      nmi_ack_i && watchdog_overflow_irq_o && mode_o[4] |=> grant_wdt_o)
      else $error("wdt");
   pin_serve_a: assert property (
      pin_srv_r && !mode_o[4] |-> !grant_wdt_o) else $error("serve");
   grant_drop_a: assert property (
      grant_wdt_o |-> $past(nmi_ack_i && watchdog_overflow_irq_o)
      && !watchdog_overflow_irq_o) else $error("grant");
   cover property (grant_wdt_o);
   cover property (operand_err_o);
   cover property (mode_o[7] && watchdog_overflow_irq_o);
   cover property (pin_srv_r && watchdog_overflow_irq_o);
endmodule
bind plwdt_top plwdt_chk chk (.clk_i, .rst_b_i, .wr_valid_i, .wr_dedicated_i,
   .wr_op3_i, .wr_op4_i, .mode_o, .operand_err_o, .nmi_ack_i, .pin_irq_o,
   .watchdog_overflow_irq_o, .grant_wdt_o, .grant_pin_o, .nmi_done_i);

// ==== verification/plwdt_core_model.sv ====
/* Core model answering the watchdog interrupt handshake.
   Assumes the bench opens the acknowledge window. */
`timescale 1ns/1ps
module plwdt_core_model #(parameter int DONE_DLY = 6) (
   // Bench control and handshake
   input  wire logic clk_i,
   input  wire logic ack_en_i,
   input  wire logic grant_pin_i,
   output logic      nmi_ack_o,
   output logic      nmi_done_o
);
   int busy = 0;
   // Held off by the bench so both requests can queue up
   assign nmi_ack_o = ack_en_i;
   // Pin handler runs a while, then returns
   always @(posedge clk_i) begin
      nmi_done_o <= (busy == 1);
      busy <= grant_pin_i ? DONE_DLY : (busy > 0 ? busy - 1 : 0);
   end
endmodule

// ==== verification/testbench.sv ====
/* Self-checking bench for the program loop watchdog.
   Assumes overflow counts 32/48/64/80 and the core model. */
`timescale 1ns/1ps
module testbench;
   // Stimulus, outputs and bookkeeping
   logic        clk_i = 1'b0, rst_b_i = 1'b0, wr_valid_i = 1'b0;
   logic        wr_dedicated_i = 1'b0, nmi_pin_i = 1'b0, ack_en = 1'b0;
   logic        nmi_ack_i, nmi_done_i, operand_err_o, pin_irq_o;
   logic        watchdog_overflow_irq_o, grant_wdt_o, grant_pin_o;
   logic [7:0]  wr_op3_i = 8'h00, wr_op4_i = 8'h00, mode_o, v, prev;
   logic [19:0] instr_addr_i = 20'h0_0000, err_addr_o;
   logic [23:0] exp_q[$];
   int          seed = 37677, error_cnt = 0, samples_checked = 0, n, lo;
   // Short overflow counts keep the run brief
   plwdt_top #(24'h00_0020, 24'h00_0030, 24'h00_0040, 24'h00_0050) dut (
      .clk_i, .rst_b_i, .wr_valid_i, .wr_dedicated_i, .wr_op3_i, .wr_op4_i,
      .instr_addr_i, .mode_o, .operand_err_o, .err_addr_o, .nmi_pin_i,
      .nmi_ack_i, .nmi_done_i, .watchdog_overflow_irq_o, .pin_irq_o,
      .grant_wdt_o, .grant_pin_o);
   plwdt_core_model core (.clk_i, .ack_en_i(ack_en),
      .grant_pin_i(grant_pin_o), .nmi_ack_o(nmi_ack_i),
      .nmi_done_o(nmi_done_i));
   initial forever #10 clk_i = ~clk_i;
   task automatic check(input string nm, input logic [23:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One decoded write, noting what it should cause
   task automatic wr(input logic d, input logic [7:0] a, b);
      @(posedge clk_i) #1;
      {wr_valid_i, wr_dedicated_i, wr_op3_i, wr_op4_i} = {1'b1, d, a, b};
      instr_addr_i = 20'($random(seed));
      if (d && a !== ~b) exp_q.push_back({4'h1, instr_addr_i});
      else if (d && !mode_o[7] && a !== mode_o)
         exp_q.push_back({16'h4000, a});
      @(posedge clk_i) #1;
      wr_valid_i = 1'b0;
   endtask
   task automatic rst();
      @(posedge clk_i) #1;
      rst_b_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      check("reset", {16'h0000, mode_o}, 24'h00_0000);
   endtask
   task automatic finish_test();
      error_cnt += exp_q.size();
      $display("Checked %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watcher: each event seen against the oldest note
   initial forever begin
      @(posedge clk_i) #1;
      if (rst_b_i === 1'b1) begin
         if (operand_err_o === 1'b1)
            check("err", {4'h1, err_addr_o}, exp_q.pop_front());
         if (grant_wdt_o === 1'b1)
            check("wdt", 24'h20_0000, exp_q.pop_front());
         if (grant_pin_o === 1'b1)
            check("pin", 24'h30_0000, exp_q.pop_front());
         if (mode_o !== prev)
            check("mode", {16'h4000, mode_o}, exp_q.pop_front());
      end
      prev = mode_o;
   end
   initial begin
      repeat (20) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      check("reset", {16'h0000, mode_o}, 24'h00_0000);
      wr(1'b0, 8'h80, 8'h7F);
      wr(1'b1, 8'h80, 8'h81);
      check("mode", {16'h0000, mode_o}, 24'h00_0000);
      rst();
      // Every interval, both priorities, restarts and locked writes
      for (int i = 0; i < 4; i++) begin
         v = {3'b100, i[0], 1'b0, i[1:0], 1'b0};
         wr(1'b1, v, ~v);
         nmi_pin_i = 1'b1;
         repeat ($unsigned($random(seed)) % 4) @(posedge clk_i);
         wr(1'b1, v, ~v);
         wr(1'b1, 8'h00, 8'hFF);
         wr(1'b1, v ^ 8'h16, ~v ^ 8'h16);
         check("lock", {16'h0000, mode_o}, {16'h0000, v});
         for (n = 0; n < 200 && watchdog_overflow_irq_o !== 1'b1; n++)
            @(posedge clk_i) #1;
         lo = 32 + 16 * i;
         check("ovf", 24'(n >= lo && n <= lo + 5), 24'h00_0001);
         check("pin irq", {23'h00_0000, pin_irq_o}, 24'h00_0001);
         if (n == 200) finish_test();
         exp_q.push_back(i[0] ? 24'h20_0000 : 24'h30_0000);
         exp_q.push_back(i[0] ? 24'h30_0000 : 24'h20_0000);
         ack_en = 1'b1;
         for (n = 0; n < 100 && exp_q.size() > 0; n++) @(posedge clk_i) #1;
         if (n == 100) finish_test();
         {ack_en, nmi_pin_i} = 2'b00;
         rst();
      end
      finish_test();
   end
endmodule
